// ==== core/omdd_ctrl.sv ====
/*
  Output mute and divider dynamic delay control registers on AHB-Lite.
  Assumes a single AHB-Lite master, whole-word single transfers, and a
  reference-valid level synchronous to hclk.
*/
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "omdd_defs.svh"
// Summary of operation
// - A channel whose auto-silence bit is 1 is disabled while the reference is invalid.
// - A channel whose auto-silence bit is 0 keeps running regardless of the reference.
// - All eight channel auto-silence bits reset to 1.
// - A flag pin set to carry a clock with its bit at 1 is disabled while the reference is invalid.
// - A flag pin not carrying a clock ignores its auto-silence bit.
// - Flag pin 1 bit resets to 1, flag pin 0 bit to 0, bits 7 to 2 are reserved.
// - Six margin delay enables cover dividers 7 to 4 and the pairs 2-3 and 0-1, above divide 8.
// - The six margin delay enables reset to 0 and bits 7 to 6 are reserved.
module omdd_ctrl
  import omdd_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Device side
  input  wire logic        ref_valid,
  input  wire logic [1:0]  flag_is_clock,
  input  wire logic [7:0]  div_value [6],
  output logic      [7:0]  chan_en,
  output logic      [1:0]  flag_en,
  output logic      [5:0]  div_margin_en
);

  logic [7:0]  chan_mute_reg;
  logic [7:0]  chan_mute_next;
  logic [7:0]  flag_mute_reg;
  logic [7:0]  flag_mute_next;
  logic [7:0]  div_dly_reg;
  logic [7:0]  div_dly_next;
  omdd_sel_t   wsel_reg;
  omdd_sel_t   wsel_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [5:0]  margin_reg;
  logic [5:0]  margin_next;
  omdd_sel_t   asel;
  logic        access;

  omdd_gate_if gif ();

  ////////////////////////////////////////////////////////////////////////
  // Bus address phase; always zero wait state, always OKAY
  assign access    = hsel && hready && htrans[1];
  assign asel      = omdd_decode(haddr);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  // Register next values; data phase write uses latched select
  always_comb begin
    chan_mute_next = chan_mute_reg;
    flag_mute_next = flag_mute_reg;
    div_dly_next   = div_dly_reg;
    wsel_next      = OMDD_SEL_NONE;
    rdata_next     = 32'h0000_0000;
    case (wsel_reg)
      OMDD_SEL_CHAN: begin
        chan_mute_next = hwdata[7:0] & `OMDD_MASK_CHAN_MUTE;
      end
      OMDD_SEL_FLAG: begin
        // Reserved bits dropped on write
        flag_mute_next = hwdata[7:0] & `OMDD_MASK_FLAG_MUTE;
      end
      OMDD_SEL_DLY: begin
        div_dly_next = hwdata[7:0] & `OMDD_MASK_DIV_DLY;
      end
      default: begin
      end
    endcase
    if (access) begin
      if (hwrite) begin
        wsel_next = asel;
      end else begin
        // Read data sampled in address phase, presented next cycle
        case (asel)
          OMDD_SEL_CHAN: rdata_next = {24'h00_0000, chan_mute_next};
          OMDD_SEL_FLAG: rdata_next = {24'h00_0000, flag_mute_next};
          OMDD_SEL_DLY:  rdata_next = {24'h00_0000, div_dly_next};
          default:       rdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  // Register update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_mute_reg <= `OMDD_RST_CHAN_MUTE;
      flag_mute_reg <= `OMDD_RST_FLAG_MUTE;
      div_dly_reg   <= `OMDD_RST_DIV_DLY;
      wsel_reg      <= OMDD_SEL_NONE;
      rdata_reg     <= 32'h0000_0000;
    end else begin
      chan_mute_reg <= chan_mute_next;
      flag_mute_reg <= flag_mute_next;
      div_dly_reg   <= div_dly_next;
      wsel_reg      <= wsel_next;
      rdata_reg     <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Margin enables; only dividers above the minimum may margin
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      margin_next[i] = div_dly_reg[i] && (div_value[i] > `OMDD_MARGIN_MIN_DIV);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      margin_reg <= 6'h00;
    end else begin
      margin_reg <= margin_next;
    end
  end

  assign div_margin_en = margin_reg;

  ////////////////////////////////////////////////////////////////////////
  // Gating of the outputs
  assign gif.chan_silence  = chan_mute_reg;
  assign gif.flag_silence  = flag_mute_reg[1:0];
  assign gif.flag_is_clock = flag_is_clock;
  assign gif.ref_invalid   = !ref_valid;

  omdd_gate u_gate (
    .hclk    (hclk),
    .hresetn (hresetn),
    .g       (gif.gate)
  );

  assign chan_en = gif.chan_en;
  assign flag_en = gif.flag_en;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_rst_chan;
    @(posedge hclk) $rose(hresetn) |-> chan_mute_reg == 8'hff;
  endproperty
  a_rst_chan: assert property (p_rst_chan) else $error("channel bits not reset to 1");

  property p_rst_flag;
    @(posedge hclk) $rose(hresetn) |-> flag_mute_reg == 8'h02;
  endproperty
  a_rst_flag: assert property (p_rst_flag) else $error("flag bits wrong after reset");

  property p_rsvd_flag;
    @(posedge hclk) disable iff (!hresetn) flag_mute_reg[7:2] == 6'h00;
  endproperty
  a_rsvd_flag: assert property (p_rsvd_flag) else $error("flag reserved bits set");

  property p_rsvd_dly;
    @(posedge hclk) disable iff (!hresetn) div_dly_reg[7:6] == 2'b00;
  endproperty
  a_rsvd_dly: assert property (p_rsvd_dly) else $error("delay reserved bits set");

  property p_margin;
    @(posedge hclk) disable iff (!hresetn)
      (div_dly_reg[0] && div_value[0] > 8'h08) |=> div_margin_en[0];
  endproperty
  a_margin: assert property (p_margin) else $error("pair 0-1 margin not enabled");

  property p_margin_low;
    @(posedge hclk) disable iff (!hresetn)
      (div_value[5] <= 8'h08) |=> !div_margin_en[5];
  endproperty
  a_margin_low: assert property (p_margin_low) else $error("margin at low divide");

  property p_write;
    @(posedge hclk) disable iff (!hresetn)
      (access && hwrite && asel == OMDD_SEL_CHAN) ##1 1'b1 |=>
        chan_mute_reg == $past(hwdata[7:0]);
  endproperty
  a_write: assert property (p_write) else $error("channel register write lost");

  property p_mute_path;
    @(posedge hclk) disable iff (!hresetn)
      (!ref_valid && chan_mute_reg[5]) ##1 (!ref_valid && chan_mute_reg[5]) |-> !chan_en[5];
  endproperty
  a_mute_path: assert property (p_mute_path) else $error("channel 5 kept running");

  // Delay bits come back out of reset cleared
  property p_rst_dly;
    @(posedge hclk) $rose(hresetn) |-> div_dly_reg == 8'h00;
  endproperty
  a_rst_dly: assert property (p_rst_dly) else $error("delay bits wrong after reset");

  // Read of the delay register with no write pending shows the stored bits
  property p_read_dly;
    @(posedge hclk) disable iff (!hresetn)
      (access && !hwrite && asel == OMDD_SEL_DLY && wsel_reg != OMDD_SEL_DLY) |=>
        hrdata == {24'h00_0000, $past(div_dly_reg)};
  endproperty
  a_read_dly: assert property (p_read_dly) else $error("delay register read wrong");

  // Reserved flag bits always read back as zero
  property p_rsvd_read;
    @(posedge hclk) disable iff (!hresetn)
      (access && !hwrite && asel == OMDD_SEL_FLAG) |=> hrdata[7:2] == 6'h00;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("flag reserved bits read set");

  // A cleared delay bit keeps its divider from margining
  property p_margin_off;
    @(posedge hclk) disable iff (!hresetn)
      !div_dly_reg[2] |=> !div_margin_en[2];
  endproperty
  a_margin_off: assert property (p_margin_off) else $error("divider 4 margin while off");

endmodule

// ==== common/omdd_defs.svh ====
/*
  Offsets, field positions, reset values and limits of the output mute
  and dynamic delay control block.
  Assumes inclusion by bare name from package and design files.
*/
`ifndef OMDD_DEFS_SVH
`define OMDD_DEFS_SVH

// Register indices as printed; byte address is four times the index
`define OMDD_IDX_CHAN_MUTE    8'h16
`define OMDD_IDX_FLAG_MUTE    8'h17
`define OMDD_IDX_DIV_DLY      8'h18

// Reset values
`define OMDD_RST_CHAN_MUTE    8'hff
`define OMDD_RST_FLAG_MUTE    8'h02
`define OMDD_RST_DIV_DLY      8'h00

// Writable field masks; reserved bits read zero
`define OMDD_MASK_CHAN_MUTE   8'hff
`define OMDD_MASK_FLAG_MUTE   8'h03
`define OMDD_MASK_DIV_DLY     8'h3f

// Field positions
`define OMDD_FLAG_PIN1_BIT    1
`define OMDD_FLAG_PIN0_BIT    0
`define OMDD_DLY_PAIR01_BIT   0
`define OMDD_DLY_PAIR23_BIT   1
`define OMDD_DLY_DIV4_BIT     2

// Smallest divide value that still allows margining is this plus one
`define OMDD_MARGIN_MIN_DIV   8'h08

`endif

// ==== common/omdd_pkg.sv ====
/*
  Types shared by the control block modules.
  Assumes the defs header is reachable on the include path.
*/
package omdd_pkg;
  `include "omdd_defs.svh"

  // Selected register of an access
  typedef enum logic [1:0] {
    OMDD_SEL_NONE,
    OMDD_SEL_CHAN,
    OMDD_SEL_FLAG,
    OMDD_SEL_DLY
  } omdd_sel_t;

  // Decode a word-aligned byte address into a register select
  function automatic omdd_sel_t omdd_decode(input logic [31:0] addr);
    omdd_sel_t sel;
    sel = OMDD_SEL_NONE;
    if (addr[1:0] == 2'b00) begin
      if (addr[31:2] == {22'h00_0000, `OMDD_IDX_CHAN_MUTE}) begin
        sel = OMDD_SEL_CHAN;
      end else if (addr[31:2] == {22'h00_0000, `OMDD_IDX_FLAG_MUTE}) begin
        sel = OMDD_SEL_FLAG;
      end else if (addr[31:2] == {22'h00_0000, `OMDD_IDX_DIV_DLY}) begin
        sel = OMDD_SEL_DLY;
      end
    end
    return sel;
  endfunction
endpackage

// ==== common/omdd_gate_if.sv ====
/*
  Carries the mute settings and reference state to the gating module,
  and the glitch-free enables back.
  Assumes a single clock domain.
*/
`timescale 1ns/1ns
interface omdd_gate_if;
  logic [7:0] chan_silence;
  logic [1:0] flag_silence;
  logic [1:0] flag_is_clock;
  logic       ref_invalid;
  logic [7:0] chan_en;
  logic [1:0] flag_en;

  modport ctrl (output chan_silence, output flag_silence, output flag_is_clock,
                output ref_invalid, input chan_en, input flag_en);
  modport gate (input chan_silence, input flag_silence, input flag_is_clock,
                input ref_invalid, output chan_en, output flag_en);
endinterface

// ==== core/omdd_gate.sv ====
/*
  Registered output enables for the eight channels and two flag pins.
  Assumes the output stages sample these enables only on their own
  clock low phase, so a registered enable never cuts a pulse short.
*/
`timescale 1ns/1ns
module omdd_gate
  import omdd_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Settings and enables
  omdd_gate_if.gate g
);

  logic [7:0] chan_en_reg;
  logic [7:0] chan_en_next;
  logic [1:0] flag_en_reg;
  logic [1:0] flag_en_next;

  ////////////////////////////////////////////////////////////////////////
  // Enable computation
  always_comb begin
    chan_en_next = ~(g.chan_silence & {8{g.ref_invalid}});
    // Pins not carrying a clock ignore their bit
    flag_en_next = ~(g.flag_silence & g.flag_is_clock & {2{g.ref_invalid}});
  end

  // Registered so enables change only on clean edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_en_reg <= 8'hff;
      flag_en_reg <= 2'b11;
    end else begin
      chan_en_reg <= chan_en_next;
      flag_en_reg <= flag_en_next;
    end
  end

  assign g.chan_en = chan_en_reg;
  assign g.flag_en = flag_en_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_chan_mute;
    @(posedge hclk) disable iff (!hresetn)
      (g.ref_invalid && g.chan_silence[0]) |=> !g.chan_en[0];
  endproperty
  a_chan_mute: assert property (p_chan_mute) else $error("channel 0 not muted");

  property p_chan_run;
    @(posedge hclk) disable iff (!hresetn)
      !g.chan_silence[7] |=> g.chan_en[7];
  endproperty
  a_chan_run: assert property (p_chan_run) else $error("channel 7 muted while disabled");

  property p_flag_mute;
    @(posedge hclk) disable iff (!hresetn)
      (g.ref_invalid && g.flag_silence[1] && g.flag_is_clock[1]) |=> !g.flag_en[1];
  endproperty
  a_flag_mute: assert property (p_flag_mute) else $error("flag pin 1 not muted");

  property p_flag_noclk;
    @(posedge hclk) disable iff (!hresetn)
      !g.flag_is_clock[0] |=> g.flag_en[0];
  endproperty
  a_flag_noclk: assert property (p_flag_noclk) else $error("non-clock flag pin muted");

  property p_glitch;
    @(posedge hclk) disable iff (!hresetn)
      $fell(g.chan_en[3]) |-> $past(g.ref_invalid) && $past(g.chan_silence[3]);
  endproperty
  a_glitch: assert property (p_glitch) else $error("channel 3 enable fell without cause");

endmodule

// ==== test/omdd_ctrl_tb.sv ====
/*
  Self-checking bench for the mute and margin delay control block.
  Assumes the block is the only AHB-Lite slave and that its hreadyout
  is fed back as hready.
*/
`timescale 1ns/1ns
module omdd_ctrl_tb;
  import omdd_pkg::*;
  // Bus and device side signals
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ref_valid;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0]  htrans, flag_is_clock, flag_en;
  logic [2:0]  hsize;
  logic [7:0]  div_value [6];
  logic [7:0]  chan_en, m0, m1, m2;
  logic [5:0]  div_margin_en;
  int          n_errors, n_checks;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and the single-slave ready loop
  always #4 hclk = ~hclk;
  assign hready = hreadyout;

  omdd_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ref_valid(ref_valid),
    .flag_is_clock(flag_is_clock), .div_value(div_value), .chan_en(chan_en),
    .flag_en(flag_en), .div_margin_en(div_margin_en));

  ////////////////////////////////////////////////////////////////////////////
  // Fixed-seed xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected enables, worked out independently of the design
  function automatic logic [7:0] exp_chan(input logic [7:0] m, input logic v);
    return v ? 8'hff : ~m;
  endfunction
  function automatic logic [1:0] exp_flag(input logic [1:0] m, input logic [1:0] c,
                                          input logic v);
    return ~(m & c & {2{~v}});
  endfunction
  function automatic logic [5:0] exp_marg(input logic [5:0] m);
    logic [5:0] r;
    for (int j = 0; j < 6; j++) begin
      r[j] = m[j] & (div_value[j] > 8'h08);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks
  task automatic chk_reg(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_out(input string what, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // One single transfer; hready is only ever sampled at rising edges
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    // Read data taken at the edge that closes the data phase
    rd = hrdata;
  endtask

  // Output enables after inputs have had time to pass the register
  task automatic chk_outputs();
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk_out("chan_en", exp_chan(m0, ref_valid), chan_en);
    chk_out("flag_en", {6'h00, exp_flag(m1[1:0], flag_is_clock, ref_valid)},
            {6'h00, flag_en});
    chk_out("div_margin_en", {2'b00, exp_marg(m2[5:0])}, {2'b00, div_margin_en});
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    stop_test();
  end

  // Main sequence
  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000;
    htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0000_0000;
    ref_valid = 1'b0; flag_is_clock = 2'b11; seed = 32'h0000_1fbd;
    n_errors = 0; n_checks = 0;
    for (int j = 0; j < 6; j++) div_value[j] = 8'h09;
    m0 = 8'hff; m1 = 8'h02; m2 = 8'h00;
    repeat (5) @(posedge hclk);
    // Reset defaults, checked with the reference invalid
    @(negedge hclk);
    chk_out("chan_en in reset", 8'hff, chan_en);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h0000_0058, 32'h0000_0000);
    chk_reg("reset 0x58", 32'h0000_00ff, rd);
    bus(1'b0, 32'h0000_005c, 32'h0000_0000);
    chk_reg("reset 0x5c", 32'h0000_0002, rd);
    bus(1'b0, 32'h0000_0060, 32'h0000_0000);
    chk_reg("reset 0x60", 32'h0000_0000, rd);
    chk_outputs();
    // Random settings; reserved bits written as zero
    for (int i = 0; i < 40; i++) begin
      m0 = 8'(rnd());
      m1 = 8'(rnd()) & 8'h03;
      m2 = 8'(rnd()) & 8'h3f;
      bus(1'b1, 32'h0000_0058, {24'h00_0000, m0});
      bus(1'b1, 32'h0000_005c, {24'h00_0000, m1});
      bus(1'b1, 32'h0000_0060, {24'h00_0000, m2});
      bus(1'b0, 32'h0000_0060, 32'h0000_0000);
      chk_reg("read 0x60", {24'h00_0000, m2}, rd);
      bus(1'b0, 32'h0000_005c, 32'h0000_0000);
      chk_reg("read 0x5c", {24'h00_0000, m1}, rd);
      bus(1'b0, 32'h0000_0058, 32'h0000_0000);
      chk_reg("read 0x58", {24'h00_0000, m0}, rd);
      @(posedge hclk);
      ref_valid     <= (i < 2) ? 1'b0 : 1'(rnd());
      flag_is_clock <= 2'(rnd());
      // Divide values straddle the margining threshold
      for (int j = 0; j < 6; j++) div_value[j] <= {4'h0, seed[4*j+:4]} + 8'h01;
      chk_outputs();
    end
    // Unmapped and unaligned places leave the channel register alone
    bus(1'b1, 32'h0000_0064, 32'h0000_00ff);
    bus(1'b1, 32'h0000_0059, {24'h00_0000, ~m0});
    bus(1'b0, 32'h0000_0064, 32'h0000_0000);
    chk_reg("read unmapped", 32'h0000_0000, rd);
    bus(1'b0, 32'h0000_0058, 32'h0000_0000);
    chk_reg("0x58 after stray", {24'h00_0000, m0}, rd);
    // Mid-run reset puts the defaults back over written values
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk_out("chan_en in second reset", 8'hff, chan_en);
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h0000_0058, 32'h0000_0000);
    chk_reg("0x58 after second reset", 32'h0000_00ff, rd);
    bus(1'b0, 32'h0000_005c, 32'h0000_0000);
    chk_reg("0x5c after second reset", 32'h0000_0002, rd);
    bus(1'b0, 32'h0000_0060, 32'h0000_0000);
    chk_reg("0x60 after second reset", 32'h0000_0000, rd);
    stop_test();
  end
endmodule
